// ---- logic/top_level_irq_pend_status.sv ----
// top-level interrupt pending, active, missed and fault status registers
`include "irq_pend_defs.svh"
`default_nettype none
module top_level_irq_pend_status (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic [31:0]         addr_in,
    input  wire logic [31:0]         wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic      [31:0]         rdata_out,
    input  wire logic [31:0]         src_irq_in,
    input  wire logic [31:0]         src_ack_in,
    input  wire logic [31:0]         src_done_in,
    output logic      [31:0]         pending_out,
    input  wire logic                fault_in,
    input  wire logic                fault_width_in,
    input  wire logic                fault_prot_in,
    input  wire logic                fault_range_in,
    output logic                     irq_out
);
    irq_pend_pkg::word_t pending_reg;
    irq_pend_pkg::word_t active_reg;
    irq_pend_pkg::word_t missed_reg;
    irq_pend_pkg::word_t status_reg;
    irq_pend_pkg::word_t mask_reg;
    irq_pend_pkg::word_t pending_next;
    irq_pend_pkg::word_t active_next;
    irq_pend_pkg::word_t missed_next;
    irq_pend_pkg::word_t status_next;
    irq_pend_pkg::word_t lost_hits;
    logic        [3:0]   fault_cause;
    logic                wr_set;
    logic                wr_clr;
    logic                wr_miss;
    logic                wr_fault;

    localparam irq_pend_pkg::word_t src_bit_map  = `PEND_SRC_MASK;
    localparam irq_pend_pkg::word_t lost_bit_map = `MISSED_SRC_MASK;

    ////////////////////////////////////////////////////////////////
    // write decode
    assign wr_set   = wr_in && (addr_in == `PEND_SET_ADDR);
    assign wr_clr   = wr_in && (addr_in == `PEND_CLEAR_ADDR);
    assign wr_miss  = wr_in && (addr_in == `MISSED_ADDR);
    assign wr_fault = wr_in && (addr_in == `FAULT_CAUSE_ADDR);

    ////////////////////////////////////////////////////////////////
    // pending: hardware and set writes win over clear writes
    always_comb begin
        pending_next = pending_reg;
        if (wr_clr) begin
            pending_next = pending_next & ~(wdata_in & `PEND_SRC_MASK);
        end
        if (wr_set) begin
            pending_next = pending_next | (wdata_in & `PEND_SRC_MASK);
        end
        pending_next = (pending_next | src_irq_in) & ~src_ack_in;
        pending_next = pending_next & `PEND_SRC_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pending_reg <= `RESET_VALUE;
        end else begin
            pending_reg <= pending_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // active: set on acknowledge, cleared on handler completion
    always_comb begin
        active_next = ((active_reg & ~src_done_in) | src_ack_in) & `PEND_SRC_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            active_reg <= `RESET_VALUE;
        end else begin
            active_reg <= active_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // missed: a source event arriving while already pending is lost
    assign lost_hits = src_irq_in & pending_reg & ~src_ack_in & `MISSED_SRC_MASK;

    always_comb begin
        missed_next = missed_reg;
        if (wr_miss) begin
            missed_next = missed_next & ~wdata_in;
        end
        missed_next = (missed_next | lost_hits) & `MISSED_SRC_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            missed_reg <= `RESET_VALUE;
        end else begin
            missed_reg <= missed_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // fault cause
    fault_cause_cell u_fault (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .fault_in       (fault_in),
        .fault_width_in (fault_width_in),
        .fault_prot_in  (fault_prot_in),
        .fault_range_in (fault_range_in),
        .clear_in       (wr_fault),
        .clear_bits_in  (wdata_in[3:0]),
        .cause_out      (fault_cause)
    );

    ////////////////////////////////////////////////////////////////
    // event status and mask
    always_comb begin
        status_next = status_reg;
        if (wr_in && (addr_in == `STATUS_ADDR)) begin
            status_next = status_next & ~wdata_in;
        end
        status_next[`EVT_LOST_BIT]  = status_next[`EVT_LOST_BIT] | (|lost_hits);
        status_next[`EVT_FAULT_BIT] = status_next[`EVT_FAULT_BIT] | fault_in;
        status_next = status_next & `EVT_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_reg <= `RESET_VALUE;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mask_reg <= `RESET_VALUE;
        end else if (wr_in && (addr_in == `MASK_ADDR)) begin
            mask_reg <= wdata_in & `EVT_MASK;
        end
    end

    assign irq_out     = |(status_reg & mask_reg);
    assign pending_out = pending_reg;

    ////////////////////////////////////////////////////////////////
    // read port
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= `RESET_VALUE;
        end else if (rd_in) begin
            case (addr_in)
                `PEND_SET_ADDR:    rdata_out <= pending_reg;
                `PEND_CLEAR_ADDR:  rdata_out <= pending_reg;
                `ACTIVE_ADDR:      rdata_out <= active_reg;
                `MISSED_ADDR:      rdata_out <= missed_reg;
                `FAULT_CAUSE_ADDR: rdata_out <= {28'h000_0000, fault_cause};
                `STATUS_ADDR:      rdata_out <= status_reg;
                `MASK_ADDR:        rdata_out <= mask_reg;
                default:           rdata_out <= `RESET_VALUE;
            endcase
        end else begin
            rdata_out <= `RESET_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    a_clear_takes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_clr && wdata_in[16] && !src_irq_in[16]) |=> !pending_reg[16])
        else $error("debug pending not cleared");

    a_clear_mac: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_clr && wdata_in[10] && !src_irq_in[10]) |=> !pending_reg[10])
        else $error("mac receive pending not cleared");

    a_clear_other: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_clr && wdata_in[2] && !src_irq_in[2]) |=> !pending_reg[2])
        else $error("management pending not cleared");

    a_zero_keeps: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_clr && !wdata_in[7] && pending_reg[7] && !src_ack_in[7]) |=> pending_reg[7])
        else $error("zero write changed pending");

    a_hw_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_clr && src_irq_in[16] && !src_ack_in[16]) |=> pending_reg[16])
        else $error("source event lost to clear write");

    a_pend_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!wr_clr && !wr_set && !(|src_irq_in) && !(|src_ack_in)) |=> $stable(pending_reg))
        else $error("pending changed with no cause");

    a_set_pends: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_set && wdata_in[9] && !src_ack_in[9]) |=> pending_reg[9])
        else $error("set write did not pend");

    a_read_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `PEND_SET_ADDR)) |=> (rdata_out == $past(pending_reg)))
        else $error("set address read wrong");

    a_read_pend: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `PEND_CLEAR_ADDR)) |=> (rdata_out == $past(pending_reg)))
        else $error("clear address read wrong");

    a_active_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        src_ack_in[3] |=> active_reg[3])
        else $error("active bit not set on acknowledge");

    a_active_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!(|src_ack_in) && !(|src_done_in)) |=> $stable(active_reg))
        else $error("active changed with no cause");

    a_read_active: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `ACTIVE_ADDR)) |=> (rdata_out == $past(active_reg)))
        else $error("active read wrong");

    a_lost_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (src_irq_in[15] && pending_reg[15] && !src_ack_in[15]) |=> missed_reg[15])
        else $error("missed interrupt not recorded");

    a_missed_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_miss && !(|lost_hits)) |=> ((missed_reg & $past(wdata_in)) == 32'h0000_0000))
        else $error("missed bit not cleared");

    a_missed_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !wr_miss |=> ((missed_reg & $past(missed_reg)) == $past(missed_reg)))
        else $error("missed bit dropped");

    a_read_missed: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `MISSED_ADDR)) |=> (rdata_out == $past(missed_reg)))
        else $error("missed read wrong");

    a_prot_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fault_in && fault_prot_in) |=> fault_cause[`FAULT_PROT_BIT])
        else $error("protection fault not recorded");

    a_range_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fault_in && fault_range_in) |=> fault_cause[`FAULT_RANGE_BIT])
        else $error("range fault not recorded");

    a_fault_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!fault_in && !wr_fault) |=> $stable(fault_cause))
        else $error("fault cause changed with no cause");

    a_fault_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_fault && !fault_in) |=> ((fault_cause & $past(wdata_in[3:0])) == 4'h0))
        else $error("fault cause not cleared");

    a_read_fault: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `FAULT_CAUSE_ADDR)) |=> (rdata_out[31:4] == 28'h000_0000))
        else $error("fault read upper bits set");

    a_reserved_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pending_reg[31:17] == 15'h0000) && !missed_reg[16] && !active_reg[13])
        else $error("reserved bit set");

    a_reset_zero: assert property (@(posedge clk_in)
        sys_rst_in |=> (pending_reg == 32'h0000_0000) && (missed_reg == 32'h0000_0000))
        else $error("registers not zero after reset");

    a_reset_rest: assert property (@(posedge clk_in)
        sys_rst_in |=> (active_reg == 32'h0000_0000) && (status_reg == 32'h0000_0000)
            && (mask_reg == 32'h0000_0000) && (fault_cause == 4'h0) && (rdata_out == 32'h0000_0000))
        else $error("state not zero after reset");

    a_status_lost: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (|lost_hits) |=> status_reg[`EVT_LOST_BIT])
        else $error("lost event not flagged");

    a_status_fault: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fault_in |=> status_reg[`EVT_FAULT_BIT])
        else $error("fault event not flagged");

    a_status_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && (addr_in == `STATUS_ADDR) && wdata_in[0] && !(|lost_hits)) |=> !status_reg[0])
        else $error("status bit not cleared");

    a_mask_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && (addr_in == `MASK_ADDR)) |=> (mask_reg == ($past(wdata_in) & `EVT_MASK)))
        else $error("mask write wrong");

    a_irq_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (mask_reg == 32'h0000_0000) |-> !irq_out)
        else $error("interrupt raised while masked");

    a_read_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !rd_in |=> (rdata_out == 32'h0000_0000))
        else $error("read data not zero when idle");

    a_read_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `STATUS_ADDR)) |=> (rdata_out == $past(status_reg)))
        else $error("status read wrong");

    a_read_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && (addr_in == `MASK_ADDR)) |=> (rdata_out == $past(mask_reg)))
        else $error("mask read wrong");

    ////////////////////////////////////////////////////////////////
    // per-source checks
    for (genvar i = 0; i < 32; i++) begin : g_bit_checks
        if (src_bit_map[i]) begin : g_src
            a_clear_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                (wr_clr && wdata_in[i] && !src_irq_in[i]) |=> !pending_reg[i])
                else $error("pending bit not cleared");

            a_zero_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                (wr_clr && !wdata_in[i] && pending_reg[i] && !src_ack_in[i]) |=> pending_reg[i])
                else $error("zero write changed pending bit");

            a_set_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                (wr_set && wdata_in[i] && !src_ack_in[i]) |=> pending_reg[i])
                else $error("set write did not pend bit");

            a_ack_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                src_ack_in[i] |=> (active_reg[i] && !pending_reg[i]))
                else $error("acknowledge not taken");

            a_done_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                (src_done_in[i] && !src_ack_in[i]) |=> !active_reg[i])
                else $error("active bit not cleared on completion");
        end else begin : g_resv
            a_resv_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                !pending_reg[i] && !active_reg[i])
                else $error("reserved source bit set");
        end

        if (lost_bit_map[i]) begin : g_lost
            a_lost_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                (src_irq_in[i] && pending_reg[i] && !src_ack_in[i]) |=> missed_reg[i])
                else $error("missed bit not recorded");
        end else begin : g_no_lost
            a_no_lost: assert property (@(posedge clk_in) disable iff (sys_rst_in)
                !missed_reg[i])
                else $error("reserved missed bit set");
        end
    end

    ////////////////////////////////////////////////////////////////
    // coverage
    c_lost_event: cover property (@(posedge clk_in) |lost_hits);
    c_fault_again: cover property (@(posedge clk_in) fault_cause[0]);
    c_irq_raised: cover property (@(posedge clk_in) irq_out);
    c_clear_write: cover property (@(posedge clk_in) wr_clr && |pending_reg);
    c_active_set: cover property (@(posedge clk_in) |active_reg);
endmodule : top_level_irq_pend_status
`default_nettype wire

// ---- logic/irq_pend_defs.svh ----
// constants for the top-level interrupt pending and fault status block
// What this block does
// - write one clears debug and external pending
// - write one clears mac pending bits
// - write one clears other source pending
// - writing zero leaves pending state unchanged
// - read-only active register, same bit layout
// - missed source event sets its lost bit, except debug source bit 16
// - wrong width access sets fault bit three
// - unprivileged protected write sets bit two
// - out of range access sets bit one
// - fault while cause set sets bit zero
// - all four registers reset to zero
// - write one to set register pends source
`ifndef IRQ_PEND_DEFS_SVH
`define IRQ_PEND_DEFS_SVH
`define PEND_SET_ADDR     32'he000_e200
`define PEND_CLEAR_ADDR   32'he000_e280
`define ACTIVE_ADDR       32'he000_e300
`define FAULT_CAUSE_ADDR  32'he000_ed3c
`define MISSED_ADDR       32'h4000_a820
`define STATUS_ADDR       32'h4000_a900
`define MASK_ADDR         32'h4000_a904
`define PEND_SRC_MASK     32'h0001_d7bc
`define MISSED_SRC_MASK   32'h0000_d7bc
`define FAULT_MASK        32'h0000_000f
`define RESET_VALUE       32'h0000_0000
`define FAULT_WIDTH_BIT   3
`define FAULT_PROT_BIT    2
`define FAULT_RANGE_BIT   1
`define FAULT_AGAIN_BIT   0
`define EVT_LOST_BIT      0
`define EVT_FAULT_BIT     1
`define EVT_MASK          32'h0000_0003
`endif

// ---- logic/irq_pend_pkg.sv ----
// types for the top-level interrupt pending and fault status block
`default_nettype none
package irq_pend_pkg;
    typedef logic [31:0] word_t;
endpackage : irq_pend_pkg
`default_nettype wire

// ---- logic/fault_cause_cell.sv ----
// sticky auxiliary bus fault cause register
`include "irq_pend_defs.svh"
`default_nettype none
module fault_cause_cell (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                fault_in,
    input  wire logic                fault_width_in,
    input  wire logic                fault_prot_in,
    input  wire logic                fault_range_in,
    input  wire logic                clear_in,
    input  wire logic [3:0]          clear_bits_in,
    output logic      [3:0]          cause_out
);
    logic [3:0] cause_next;
    logic [3:0] set_bits;

    always_comb begin
        set_bits = 4'h0;
        if (fault_in) begin
            set_bits[`FAULT_WIDTH_BIT] = fault_width_in;
            set_bits[`FAULT_PROT_BIT]  = fault_prot_in;
            set_bits[`FAULT_RANGE_BIT] = fault_range_in;
            set_bits[`FAULT_AGAIN_BIT] = |cause_out[3:1];
        end
        cause_next = cause_out;
        if (clear_in) begin
            cause_next = cause_next & ~clear_bits_in;
        end
        cause_next = cause_next | set_bits;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cause_out <= 4'h0;
        end else begin
            cause_out <= cause_next;
        end
    end

    a_again_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fault_in && |cause_out[3:1]) |=> cause_out[0])
        else $error("repeat fault not recorded");
    a_width_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fault_in && fault_width_in) |=> cause_out[3])
        else $error("width fault not recorded");
endmodule : fault_cause_cell
`default_nettype wire

// ---- sim/core_model.sv ----
// core model: acknowledges the lowest pending source, then completes it
`default_nettype none
module core_model #(
    parameter int SERVICE = 8
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        take_in,
    input  wire logic [31:0] pending_in,
    output logic      [31:0] ack_out,
    output logic      [31:0] done_out
);
    logic [31:0] held_reg;
    logic [7:0]  count_reg;
    always_ff @(posedge clk_in) begin
        ack_out  <= '0;
        done_out <= '0;
        if (sys_rst_in) begin
            held_reg  <= '0;
            count_reg <= '0;
        end else if (held_reg != '0) begin
            count_reg <= count_reg + 8'h01;
            if (count_reg == 8'(SERVICE)) begin
                done_out  <= held_reg;
                held_reg  <= '0;
                count_reg <= '0;
            end
        end else if (take_in && pending_in != '0) begin
            held_reg <= pending_in & (~pending_in + 32'h0000_0001);
            ack_out  <= pending_in & (~pending_in + 32'h0000_0001);
        end
    end
endmodule : core_model
`default_nettype wire

// ---- sim/tb_top_level_irq_pend_status.sv ----
// self-checking bench for the interrupt pending and fault status block
`include "irq_pend_defs.svh"
`default_nettype none
module tb_top_level_irq_pend_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in     = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic [31:0] addr_in    = '0;
    logic [31:0] wdata_in   = '0;
    logic        wr_in      = 1'h0;
    logic        rd_in      = 1'h0;
    logic [31:0] src_irq_in = '0;
    logic        fault_in   = 1'h0;
    logic [2:0]  why        = '0;
    logic        take       = 1'h0;
    logic [31:0] rdata_out, src_ack_in, src_done_in, pending_out, exp;
    logic        irq_out;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #20 clk_in = ~clk_in;
    top_level_irq_pend_status top_level_irq_pend_status_i (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .src_irq_in(src_irq_in),
        .src_ack_in(src_ack_in), .src_done_in(src_done_in), .pending_out(pending_out),
        .fault_in(fault_in), .fault_width_in(why[2]), .fault_prot_in(why[1]),
        .fault_range_in(why[0]), .irq_out(irq_out));
    core_model core_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .take_in(take),
        .pending_in(pending_out), .ack_out(src_ack_in), .done_out(src_done_in));
    task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
        #1;
    endtask : wr
    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        check(what, rdata_out, e);
    endtask : rdc
    task automatic waitfor(input int which);
        for (int n = 0; n < 20 && (which ? src_done_in : src_ack_in) === '0; n++) begin
            @(posedge clk_in);
            #1;
        end
    endtask : waitfor
    task automatic t_reset;
        rdc("pending", `PEND_CLEAR_ADDR, `RESET_VALUE);
        rdc("active", `ACTIVE_ADDR, `RESET_VALUE);
        rdc("fault", `FAULT_CAUSE_ADDR, `RESET_VALUE);
        rdc("missed", `MISSED_ADDR, `RESET_VALUE);
        rdc("unmapped", 32'h4000_0000, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pend;
        wr(`PEND_SET_ADDR, 32'hffff_ffff);
        rdc("set all", `PEND_CLEAR_ADDR, `PEND_SRC_MASK);
        rdc("set read", `PEND_SET_ADDR, `PEND_SRC_MASK);
        wr(`PEND_CLEAR_ADDR, 32'h0000_0000);
        check("clear zero", pending_out, `PEND_SRC_MASK);
        exp = `PEND_SRC_MASK;
        for (int b = 0; b < 32; b++) begin
            wr(`PEND_CLEAR_ADDR, 32'h0000_0001 << b);
            exp = exp & ~(32'h0000_0001 << b);
            check("clear bit", pending_out, exp);
        end
        wr(`ACTIVE_ADDR, 32'hffff_ffff);
        rdc("active ro", `ACTIVE_ADDR, 32'h0000_0000);
        $display("test pending done");
    endtask : t_pend
    task automatic t_active;
        wr(`PEND_SET_ADDR, 32'h0001_0080);
        take <= 1'h1;
        waitfor(0);
        check("ack", src_ack_in, 32'h0000_0080);
        rdc("active on", `ACTIVE_ADDR, 32'h0000_0080);
        check("unpended", pending_out, 32'h0001_0000);
        take <= 1'h0;
        waitfor(1);
        rdc("active off", `ACTIVE_ADDR, 32'h0000_0000);
        wr(`PEND_CLEAR_ADDR, 32'h0001_0000);
        $display("test active done");
    endtask : t_active
    task automatic t_missed;
        wr(`MASK_ADDR, 32'h0000_0007);
        rdc("mask", `MASK_ADDR, 32'h0000_0003);
        @(posedge clk_in);
        src_irq_in <= 32'h0000_0008;
        repeat (2) @(posedge clk_in);
        src_irq_in <= '0;
        rdc("missed", `MISSED_ADDR, 32'h0000_0008);
        rdc("status", `STATUS_ADDR, 32'h0000_0001);
        check("irq on", {31'h0, irq_out}, 32'h0000_0001);
        wr(`MISSED_ADDR, 32'h0000_0008);
        wr(`STATUS_ADDR, 32'h0000_0001);
        rdc("missed clr", `MISSED_ADDR, 32'h0000_0000);
        check("irq off", {31'h0, irq_out}, 32'h0000_0000);
        wr(`PEND_CLEAR_ADDR, 32'h0000_0008);
        $display("test missed done");
    endtask : t_missed
    task automatic fault(input logic [2:0] c);
        @(posedge clk_in);
        fault_in <= 1'h1;
        why      <= c;
        @(posedge clk_in);
        fault_in <= 1'h0;
        why      <= '0;
    endtask : fault
    task automatic t_fault;
        fault(3'h4);
        rdc("width", `FAULT_CAUSE_ADDR, 32'h0000_0008);
        fault(3'h2);
        rdc("again", `FAULT_CAUSE_ADDR, 32'h0000_000d);
        rdc("status", `STATUS_ADDR, 32'h0000_0002);
        wr(`FAULT_CAUSE_ADDR, 32'hffff_ffff);
        rdc("cleared", `FAULT_CAUSE_ADDR, 32'h0000_0000);
        fault(3'h1);
        rdc("range", `FAULT_CAUSE_ADDR, 32'h0000_0002);
        $display("test fault done");
    endtask : t_fault
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        t_reset;
        t_pend;
        t_active;
        t_missed;
        t_fault;
        conclude;
    end
endmodule : tb_top_level_irq_pend_status
`default_nettype wire
